// File: design/rtc_interval_timer.v
// Interval interrupt timer driven by the low-frequency clock
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`include "rtc_interval_map.vh"

module rtc_interval_timer (
  input wire core_clk,
  input wire reset_n,
  input wire [`ADDR_W-1:0] addr,
  input wire [`DATA_W-1:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [`DATA_W-1:0] rdata,
  input wire low_frequency_clock,
  input wire low_freq_osc_enable,
  input wire stop_mode,
  input wire deep_sleep_mode,
  output reg periodic_interrupt_request,
  output reg irq
);

  // ==========================================================
  // Declarations
  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_n;

  reg [`DATA_W-1:0] clock_gate_reg;
  reg [`DATA_W-1:0] clock_gate_next;
  reg counter_run_reg;
  reg counter_run_next;
  reg [`SEL_W-1:0] interval_select_reg;
  reg [`SEL_W-1:0] interval_select_next;
  reg [`DATA_W-1:0] irq_status_reg;
  reg [`DATA_W-1:0] irq_status_next;
  reg [`DATA_W-1:0] irq_mask_reg;
  reg [`DATA_W-1:0] irq_mask_next;
  reg [`DATA_W-1:0] rdata_next;

  reg lf_prev_reg;
  wire lf_level;
  wire lf_rise;
  wire rtc_clock_gate;
  wire power_down;
  wire counter_clear;
  wire counter_step;
  wire tick;

  wire hit_clock_gate;
  wire hit_control;
  wire hit_status;
  wire hit_mask;
  wire [`DATA_W-1:0] control_view;

  // ==========================================================
  // Reset release
  // Assert at once, release through two flops to avoid recovery races
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Internal reset for every flop below
  assign rst_n = rst_sync_reg;

  // ==========================================================
  // Low-frequency clock sampling
  // The slow clock is a pin, so it is sampled, not used as a clock;
  // at 200 MHz a 32 kHz edge is caught with huge margin
  level_sync lf_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .async_in(low_frequency_clock),
    .sync_out(lf_level)
  );

  // Reset level matches the idle-low pin, so no false edge after reset
  // Edge detector reads the synchronised copy only
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lf_prev_reg <= 1'b0;
    end else begin
      lf_prev_reg <= lf_level;
    end
  end

  assign lf_rise = lf_level & ~lf_prev_reg;

  // ==========================================================
  // Address decode
  // Exact match on every address bit, so no aliases answer
  assign hit_clock_gate = (addr == `ADDR_CLOCK_GATE);
  assign hit_control = (addr == `ADDR_RTC_CONTROL);
  assign hit_status = (addr == `ADDR_IRQ_STATUS);
  assign hit_mask = (addr == `ADDR_IRQ_MASK);

  // Gate bit that supplies the basic clock to the timer
  assign rtc_clock_gate = clock_gate_reg[`CLOCK_GATE_BIT];

  // Any of these conditions stops the slow clock or the timer
  assign power_down = ~low_freq_osc_enable | stop_mode | deep_sleep_mode;

  // Control register as software sees it; top nibble is constant zero
  assign control_view = {4'h0, interval_select_reg, counter_run_reg};

  // ==========================================================
  // Clock gate register
  // All eight bits are plain storage; only one steers this block
  always @* begin
    clock_gate_next = clock_gate_reg;
    if (wr_en && hit_clock_gate) begin
      clock_gate_next = wdata;
    end
  end

  // ==========================================================
  // Run bit and interval select
  // With the gate off the control register takes no writes, since its
  // clock is withheld; power-down clears run and has the last word
  always @* begin
    counter_run_next = counter_run_reg;
    if (wr_en && hit_control && rtc_clock_gate) begin
      counter_run_next = wdata[`RUN_BIT];
    end
    // Also beats a same-cycle start, so run never rises while powered down
    if (power_down) begin
      counter_run_next = 1'b0;
    end
  end

  // Select moves only while stopped, the starting write included;
  // a stopping write leaves it alone
  always @* begin
    interval_select_next = interval_select_reg;
    if (wr_en && hit_control && rtc_clock_gate) begin
      if (!counter_run_reg && wdata[`RUN_BIT]) begin
        interval_select_next = wdata[`SEL_MSB:`SEL_LSB];
      end else if (!counter_run_reg) begin
        interval_select_next = wdata[`SEL_MSB:`SEL_LSB];
      end
    end
  end

  // ==========================================================
  // Interrupt status and mask
  // A tick in the same cycle as the clearing read is kept: set wins
  always @* begin
    irq_status_next = irq_status_reg;
    if (rd_en && hit_status) begin
      irq_status_next = {`DATA_W{1'b0}};
    end
    if (tick) begin
      irq_status_next[`PERIODIC_STATUS_BIT] = 1'b1;
    end
  end

  // Only the periodic bit exists; the rest read as zero
  always @* begin
    irq_mask_next = irq_mask_reg;
    if (wr_en && hit_mask) begin
      irq_mask_next = {`DATA_W{1'b0}};
      irq_mask_next[`PERIODIC_STATUS_BIT] = wdata[`PERIODIC_STATUS_BIT];
    end
  end

  // ==========================================================
  // Read data mux
  // Unmapped addresses answer zero; data stand for one cycle only
  always @* begin
    rdata_next = {`DATA_W{1'b0}};
    if (rd_en) begin
      case (addr)
        `ADDR_CLOCK_GATE: begin
          rdata_next = clock_gate_reg;
        end
        `ADDR_RTC_CONTROL: begin
          rdata_next = control_view;
        end
        `ADDR_IRQ_STATUS: begin
          rdata_next = irq_status_reg;
        end
        `ADDR_IRQ_MASK: begin
          rdata_next = irq_mask_reg;
        end
        default: begin
          rdata_next = {`DATA_W{1'b0}};
        end
      endcase
    end
  end

  // ==========================================================
  // Register update
  // One process per register keeps each reset value beside its use
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_gate_reg <= `RESET_CLOCK_GATE;
    end else begin
      clock_gate_reg <= clock_gate_next;
    end
  end

  // Run reads zero straight after reset release
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_run_reg <= 1'b0;
    end else begin
      counter_run_reg <= counter_run_next;
    end
  end

  // Select survives every stop; only reset or a control write while stopped changes it
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      interval_select_reg <= {`SEL_W{1'b0}};
    end else begin
      interval_select_reg <= interval_select_next;
    end
  end

  // Sticky status bits
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= `RESET_IRQ_STATUS;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  // Mask bits
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_reg <= `RESET_IRQ_MASK;
    end else begin
      irq_mask_reg <= irq_mask_next;
    end
  end

  // Read data register, zero whenever no read is answered
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= {`DATA_W{1'b0}};
    end else begin
      rdata <= rdata_next;
    end
  end

  // ==========================================================
  // Counter control
  // Stopped or ungated means held at zero; a gate dropped mid-run
  // freezes the timer at zero, which software must not rely on
  assign counter_clear = ~counter_run_reg | ~rtc_clock_gate;

  // One step per detected rising edge of the slow clock
  assign counter_step = lf_rise;

  interval_counter counter (
    .clk(core_clk),
    .rst_n(rst_n),
    .clear(counter_clear),
    .step(counter_step),
    .sel(interval_select_reg),
    .tick(tick)
  );

  // ==========================================================
  // Interrupt outputs
  // Request is the raw one-cycle tick; irq is the masked sticky level
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      periodic_interrupt_request <= 1'b0;
    end else begin
      periodic_interrupt_request <= tick;
    end
  end

  // Built from next values so irq rises with the status bit itself
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_next & irq_mask_next);
    end
  end

endmodule // rtc_interval_timer

// File: design/rtc_interval_map.vh
// Register map and field constants of the interval interrupt timer
`ifndef RTC_INTERVAL_MAP_VH
`define RTC_INTERVAL_MAP_VH

// ==========================================================
// Bus geometry
`define ADDR_W 12
`define DATA_W 8

// ==========================================================
// Register byte addresses
`define ADDR_CLOCK_GATE 12'hf76
`define ADDR_RTC_CONTROL 12'hfc8
`define ADDR_IRQ_STATUS 12'hfc9
`define ADDR_IRQ_MASK 12'hfca

// ==========================================================
// Reset values
`define RESET_CLOCK_GATE 8'h00
`define RESET_RTC_CONTROL 8'h00
`define RESET_IRQ_STATUS 8'h00
`define RESET_IRQ_MASK 8'h00

// ==========================================================
// Field positions
`define CLOCK_GATE_BIT 5
`define RUN_BIT 0
`define SEL_LSB 1
`define SEL_MSB 3
`define SEL_W 3
`define PERIODIC_STATUS_BIT 0

// ==========================================================
// Counter geometry: longest period is 2^15 low-frequency cycles
`define COUNT_W 15
`define COUNT_ALL_ONES 15'h7fff

`endif

// File: design/level_sync.v
// Two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps

module level_sync (
  input wire clk,
  input wire rst_n,
  input wire async_in,
  output reg sync_out
);

  reg meta_reg;

  // ==========================================================
  // Synchroniser chain
  // First stage feeds the second stage only, nothing else looks at it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // level_sync

// File: design/interval_counter.v
// Free-running binary counter with selectable power-of-two tick
`timescale 1ns/100ps
`include "rtc_interval_map.vh"

module interval_counter (
  input wire clk,
  input wire rst_n,
  input wire clear,
  input wire step,
  input wire [`SEL_W-1:0] sel,
  output reg tick
);

  reg [`COUNT_W-1:0] count_reg;
  wire [`COUNT_W-1:0] window_mask;
  wire boundary;

  // ==========================================================
  // Period select
  // Code 0 watches all 15 bits, each higher code drops one top bit
  assign window_mask = `COUNT_ALL_ONES >> sel;
  assign boundary = ((count_reg & window_mask) == window_mask);

  // ==========================================================
  // Counter and tick
  // Clear wins over step so a stop always lands on zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= {`COUNT_W{1'b0}};
      tick <= 1'b0;
    end else if (clear) begin
      count_reg <= {`COUNT_W{1'b0}};
      tick <= 1'b0;
    end else begin
      if (step) begin
        count_reg <= count_reg + 1'b1;
      end
      // Wraps on through the boundary, never halts
      tick <= step & boundary;
    end
  end

endmodule // interval_counter

// File: testbench/rtc_interval_timer_chk.sv
// Port-level assertions for the interval interrupt timer
`timescale 1ns/100ps
`include "rtc_interval_map.vh"

module rtc_interval_timer_chk (
  input wire core_clk,
  input wire reset_n,
  input wire [`ADDR_W-1:0] addr,
  input wire [`DATA_W-1:0] wdata,
  input wire wr_en,
  input wire rd_en,
  input wire [`DATA_W-1:0] rdata,
  input wire low_frequency_clock,
  input wire low_freq_osc_enable,
  input wire stop_mode,
  input wire deep_sleep_mode,
  input wire periodic_interrupt_request,
  input wire irq
);
  // ==========
  // Shared clocking, one domain only
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire ctl_hit = addr == `ADDR_RTC_CONTROL;

  // Bus read side
  a_rdata_idle_zero: assert property (
    !$past(rd_en) |-> rdata == 8'h00) else $error("rdata not idle");
  a_ctrl_upper_zero: assert property (
    $past(rd_en && ctl_hit) |-> rdata[7:4] == 4'h0)
    else $error("control upper bits set");
  // Power-down drops the run bit
  a_stop_run_clear: assert property (
    $past(rd_en && ctl_hit && stop_mode) && $past(stop_mode, 2)
    |-> !rdata[0]) else $error("run survives stop");
  a_osc_run_clear: assert property (
    $past(rd_en && ctl_hit && !low_freq_osc_enable)
    && !$past(low_freq_osc_enable, 2) |-> !rdata[0])
    else $error("run survives osc off");
  // Requests are lone pulses, none while powered down
  a_req_spacing: assert property (
    periodic_interrupt_request |=> !periodic_interrupt_request [*8])
    else $error("request too long");
  a_stop_no_req: assert property (
    stop_mode [*5] |-> !periodic_interrupt_request)
    else $error("request in stop");
  a_osc_no_req: assert property (
    !low_freq_osc_enable [*5] |-> !periodic_interrupt_request)
    else $error("request with osc off");
  // Level drops only in the two cycles after any bus read or write
  a_irq_fall_cause: assert property (
    $fell(irq) |-> $past(rd_en) || $past(wr_en) || $past(rd_en, 2)
    || $past(wr_en, 2)) else $error("irq fell alone");
endmodule // rtc_interval_timer_chk

bind rtc_interval_timer rtc_interval_timer_chk i_chk (
  .core_clk(core_clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
  .low_frequency_clock(low_frequency_clock),
  .low_freq_osc_enable(low_freq_osc_enable), .stop_mode(stop_mode),
  .deep_sleep_mode(deep_sleep_mode),
  .periodic_interrupt_request(periodic_interrupt_request), .irq(irq));

// File: testbench/rtc_interval_timer_tb.sv
// Self-checking bench for the interval interrupt timer
`timescale 1ns/100ps
`include "rtc_interval_map.vh"

module rtc_interval_timer_tb;
  localparam [11:0] ctl = `ADDR_RTC_CONTROL;
  localparam [11:0] sts = `ADDR_IRQ_STATUS;
  reg core_clk = 1'b0;
  reg reset_n = 1'b0;
  reg [11:0] addr = 12'h000;
  reg [7:0] wdata = 8'h00;
  reg wr_en = 1'b0;
  reg rd_en = 1'b0;
  reg low_frequency_clock = 1'b0;
  reg low_freq_osc_enable = 1'b1;
  reg stop_mode = 1'b0;
  reg deep_sleep_mode = 1'b0;
  wire [7:0] rdata;
  wire periodic_interrupt_request;
  wire irq;
  int errors = 0;
  int samples_checked = 0;
  int req_count = 0;
  int n;
  int i;
  // Select, control readback, period in slow edges (0: too long)
  int rows [0:7][0:2] = '{'{7, 15, 256}, '{6, 13, 512}, '{5, 11, 1024},
    '{4, 9, 2048}, '{3, 7, 4096}, '{2, 5, 0}, '{1, 3, 0}, '{0, 1, 0}};

  rtc_interval_timer i_rtc_interval_timer (.core_clk(core_clk),
    .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .low_frequency_clock(low_frequency_clock),
    .low_freq_osc_enable(low_freq_osc_enable), .stop_mode(stop_mode),
    .deep_sleep_mode(deep_sleep_mode),
    .periodic_interrupt_request(periodic_interrupt_request), .irq(irq));

  // ==========
  // Clock, request counter, hang guard
  initial forever #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (periodic_interrupt_request === 1'b1) begin
    req_count <= req_count + 1;
  end
  initial begin
    #400000;
    errors++;
    close_out;
  end

  // ==========
  // Bus cycles, slow edges, compare, verdict
  task wr(input [11:0] a, input [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  task rd(input [11:0] a, input [7:0] e);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    // Data stand only in the cycle after the strobe; look mid-cycle
    @(negedge core_clk);
    chk(rdata, e);
  endtask
  // Slow clock stands low between bursts; 3 core cycles per phase
  task slow(input int k);
    repeat (2 * k) begin
      repeat (3) @(posedge core_clk);
      low_frequency_clock <= ~low_frequency_clock;
    end
    repeat (8) @(posedge core_clk);
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========
  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd(`ADDR_CLOCK_GATE, `RESET_CLOCK_GATE);
    rd(sts, `RESET_IRQ_STATUS);
    rd(`ADDR_IRQ_MASK, `RESET_IRQ_MASK);
    rd(12'hf77, 8'h00);
    rd(ctl, 8'h00);
    wr(ctl, 8'h0f);
    rd(ctl, 8'h00);
    wr(`ADDR_CLOCK_GATE, 8'h20);
    wr(`ADDR_IRQ_MASK, 8'hff);
    rd(`ADDR_IRQ_MASK, 8'h01);
    wr(ctl, 8'hf0);
    rd(ctl, 8'h00);
    rd(12'hfcb, 8'h00);
    for (i = 0; i < 8; i++) begin
      wr(ctl, 8'(rows[i][1]));
      rd(ctl, 8'(rows[i][1]));
      if (rows[i][2] > 0) begin
        n = req_count;
        slow(rows[i][2] - 1);
        chk(8'(req_count - n), 8'h00);
        slow(1);
        chk(8'(req_count - n), 8'h01);
      end
      wr(ctl, 8'h00);
      rd(ctl, 8'(rows[i][1]) & 8'h0e);
    end
    rd(sts, 8'h01);
    wr(ctl, 8'h0f);
    wr(ctl, 8'h03);
    rd(ctl, 8'h0f);
    slow(128);
    wr(ctl, 8'h00);
    wr(ctl, 8'h0f);
    n = req_count;
    slow(255);
    chk(8'(req_count - n), 8'h00);
    slow(1);
    @(negedge core_clk);
    chk({7'h00, irq}, 8'h01);
    // Masking drops the level, unmasking brings it back
    wr(`ADDR_IRQ_MASK, 8'h00);
    @(negedge core_clk);
    chk({7'h00, irq}, 8'h00);
    wr(`ADDR_IRQ_MASK, 8'h01);
    @(negedge core_clk);
    chk({7'h00, irq}, 8'h01);
    slow(256);
    chk(8'(req_count - n), 8'h02);
    rd(sts, 8'h01);
    @(negedge core_clk);
    chk({7'h00, irq}, 8'h00);
    rd(sts, 8'h00);
    for (i = 0; i < 3; i++) begin
      wr(ctl, 8'h0f);
      stop_mode <= i == 0;
      deep_sleep_mode <= i == 1;
      low_freq_osc_enable <= i != 2;
      repeat (4) @(posedge core_clk);
      rd(ctl, 8'h0e);
      @(posedge core_clk);
      stop_mode <= 1'b0;
      deep_sleep_mode <= 1'b0;
      low_freq_osc_enable <= 1'b1;
    end
    // Gate dropped only once stopped; control then refuses writes
    wr(`ADDR_CLOCK_GATE, 8'h00);
    wr(ctl, 8'h01);
    rd(ctl, 8'h0e);
    wr(`ADDR_CLOCK_GATE, 8'h20);
    wr(ctl, 8'h05);
    rd(ctl, 8'h05);
    // Second reset while running: registers back to reset values
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd(ctl, `RESET_RTC_CONTROL);
    rd(`ADDR_CLOCK_GATE, `RESET_CLOCK_GATE);
    rd(`ADDR_IRQ_MASK, `RESET_IRQ_MASK);
    close_out;
  end
endmodule // rtc_interval_timer_tb
